// ===== rtl/psrg_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the profile
  select and reset gating block. Assumes a 250 MHz system clock.
*/
`ifndef PSRG_CFG_SVH
`define PSRG_CFG_SVH
`define PSRG_COMMON_OFS      8'h00
`define PSRG_SIGNATURE_OFS   8'h04
`define PSRG_STATUS_OFS      8'h08
`define PSRG_IRQ_STATUS_OFS  8'h0c
`define PSRG_IRQ_MASK_OFS    8'h10
`define PSRG_PROFILE_BASE    3'b001
`define PSRG_COMMON_RST      32'h00000000
`define PSRG_SIGNATURE_RST   32'h00000000
`define PSRG_DIV_RST         32'h00040101
`define PSRG_SKEW_RST        32'h00000000
`define PSRG_REF_DIV_LSB     0
`define PSRG_FB_DIV_LSB      8
`define PSRG_OUT_DIV_LSB     16
`define PSRG_FB_SKEW_LSB     16
`define PSRG_INT_FB_BIT      24
`define PSRG_COARSE_BIT      4
`define PSRG_IRQ_GAINED_BIT  0
`define PSRG_IRQ_LOST_BIT    1
`define PSRG_CLK_MHZ         250
`define PSRG_POR_TIME_NS     2000
`define PSRG_POR_CYCLES      ((`PSRG_POR_TIME_NS * `PSRG_CLK_MHZ + 999) / 1000)
`define PSRG_VCO_STEP_NS     40
`define PSRG_VCO_STEP_CYCLES ((`PSRG_VCO_STEP_NS * `PSRG_CLK_MHZ + 999) / 1000)
`define PSRG_VCO_START       8'h32
`define PSRG_VCO_LOCK        8'hc8
`endif

// ===== rtl/psrg_pkg.sv
/*
  Types of the profile select and reset gating block.
  Assumes psrg_cfg.svh for all numeric constants.
*/
package psrg_pkg;
  typedef enum logic [1:0] {
    psrg_st_hold    = 2'b00,
    psrg_st_acquire = 2'b01,
    psrg_st_locked  = 2'b11
  } psrg_state_type;
endpackage

// ===== rtl/psrg_top.sv
/*
  Profile select, reset sequencing, lock model and output gating of a clock
  generator, with an AXI4-Lite register slave and a lock interrupt.
  Assumes all pins synchronous to sys_clk and ref_clk_in well below sys_clk.
*/
// Contract
// RULE1 - Four independent profiles are stored, any one may become active.
// RULE2 - Select pins decode binary, bit 1 high, to profile 0..3.
// RULE3 - Active profile gives dividers, output skews, feedback skew, feedback choice.
// RULE4 - Common settings apply the same under every profile.
// RULE5 - Board must assert reset after changing profile select pins.
// RULE6 - Power-up makes an internal reset acting like the external one.
// RULE7 - External reset high clears dividers and drops lock.
// RULE8 - Relock time grows with how long reset was held.
// RULE9 - Oscillator starts below 100 MHz at power-on and ramps up to lock.
// RULE10 - Gate low holds outputs at inversion level; toggling resumes on gate high.
// RULE11 - Enable input high puts its bank group in high impedance.
// RULE12 - Board should drive gate or enables from lock.
// RULE13 - Board should assert reset on reference high or low time violations.
// RULE14 - External feedback mode aligns feedback rising edge with reference edge.
// RULE15 - Internal feedback path selectable per profile with its own skew.
// RULE16 - New profile settings load at reset release, not while held.
`timescale 1ns/1ps
`default_nettype none
`include "psrg_cfg.svh"
module psrg_top
  import psrg_pkg::*;
#(
  parameter int BANKS      = 4,
  parameter int POR_CYCLES = `PSRG_POR_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              profile_sel_bit0,
  input  wire logic              profile_sel_bit1,
  input  wire logic              ext_reset_in,
  input  wire logic              ref_clk_in,
  input  wire logic              feedback_in,
  input  wire logic              output_static_gate,
  input  wire logic              bank_group_x_enable_n,
  input  wire logic              bank_group_y_enable_n,
  output logic                   lock,
  output logic [1:0]             active_profile,
  output logic [BANKS-1:0]       bank_out,
  output logic [BANKS-1:0]       bank_oe_n,
  output logic                   irq
);
  // ------------------------------------------------------------------
  // Register file and bus slave
  // ------------------------------------------------------------------
  logic [31:0] common, signature, irq_status, irq_mask;
  logic [31:0] prof_div [4];
  logic [31:0] prof_skew [4];
  logic        aw_held, w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [31:0] next_common, next_signature, next_irq_status, next_irq_mask;
  logic [31:0] next_prof_div [4];
  logic [31:0] next_prof_skew [4];
  logic        next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [7:0]  next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0]  next_w_strb;
  logic [1:0]  next_bresp, next_rresp;
  logic        ev_gained, ev_lost;
  psrg_state_type state;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign irq           = |(irq_status & irq_mask);

  always_comb begin
    logic        do_wr;
    logic        prof_hit;
    logic [31:0] clr;
    do_wr = aw_held && w_held && !s_axi_bvalid;
    prof_hit = aw_addr[7:5] == `PSRG_PROFILE_BASE;
    clr = 32'h0;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_common = common;
    next_signature = signature;
    next_irq_mask = irq_mask;
    next_prof_div = prof_div;
    next_prof_skew = prof_skew;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_wr) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = 2'b00;
      if (prof_hit && !aw_addr[2]) begin
        next_prof_div[aw_addr[4:3]] = merge(prof_div[aw_addr[4:3]], w_data, w_strb); // RULE1
      end else if (prof_hit) begin
        next_prof_skew[aw_addr[4:3]] = merge(prof_skew[aw_addr[4:3]], w_data, w_strb); // RULE1
      end else begin
        case (aw_addr)
          `PSRG_COMMON_OFS:     next_common = merge(common, w_data, w_strb); // RULE4
          `PSRG_SIGNATURE_OFS:  next_signature = merge(signature, w_data, w_strb); // RULE4
          `PSRG_IRQ_STATUS_OFS: clr = merge(32'h0, w_data, w_strb);
          `PSRG_IRQ_MASK_OFS:   next_irq_mask = merge(irq_mask, w_data, w_strb);
          `PSRG_STATUS_OFS:     next_bresp = 2'b00;
          default:              next_bresp = 2'b10;
        endcase
      end
    end
    // Set wins over a clear in the same cycle
    next_irq_status = irq_status & ~clr;
    next_irq_status[`PSRG_IRQ_GAINED_BIT] = next_irq_status[`PSRG_IRQ_GAINED_BIT] | ev_gained;
    next_irq_status[`PSRG_IRQ_LOST_BIT] = next_irq_status[`PSRG_IRQ_LOST_BIT] | ev_lost;
  end

  always_comb begin
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = 2'b00;
      next_rdata = 32'h0;
      if (s_axi_araddr[7:5] == `PSRG_PROFILE_BASE) begin
        next_rdata = s_axi_araddr[2] ? prof_skew[s_axi_araddr[4:3]] : prof_div[s_axi_araddr[4:3]];
      end else begin
        case (s_axi_araddr)
          `PSRG_COMMON_OFS:     next_rdata = common;
          `PSRG_SIGNATURE_OFS:  next_rdata = signature;
          `PSRG_STATUS_OFS:     next_rdata = {28'h0, state == psrg_st_hold, active_profile, lock};
          `PSRG_IRQ_STATUS_OFS: next_rdata = irq_status;
          `PSRG_IRQ_MASK_OFS:   next_rdata = irq_mask;
          default:              next_rresp = 2'b10;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      common <= `PSRG_COMMON_RST;
      signature <= `PSRG_SIGNATURE_RST;
      irq_status <= 32'h0;
      irq_mask <= 32'h0;
      for (int p = 0; p < 4; p++) begin
        prof_div[p] <= `PSRG_DIV_RST;
        prof_skew[p] <= `PSRG_SKEW_RST;
      end
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else begin
      common <= next_common;
      signature <= next_signature;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      prof_div <= next_prof_div;
      prof_skew <= next_prof_skew;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ------------------------------------------------------------------
  // Reset sequencer and lock model
  // ------------------------------------------------------------------
  logic [31:0] por_cnt, next_por_cnt;
  logic [7:0]  vco, next_vco, step_cnt, next_step_cnt;
  logic [31:0] act_div, act_skew, next_act_div, next_act_skew;
  logic [1:0]  next_active_profile;
  logic        aligned;
  psrg_state_type next_state;

  always_comb begin
    logic step;
    logic [1:0] sel;
    step = step_cnt == 8'h00;
    sel = {profile_sel_bit1, profile_sel_bit0}; // RULE2
    next_step_cnt = step ? 8'((`PSRG_VCO_STEP_CYCLES) - 1) : step_cnt - 8'h01;
    next_por_cnt = (por_cnt != 32'h0) ? por_cnt - 32'h1 : por_cnt; // RULE6
    next_vco = vco;
    next_state = state;
    next_act_div = act_div;
    next_act_skew = act_skew;
    next_active_profile = active_profile;
    ev_gained = 1'b0;
    ev_lost = 1'b0;
    case (state)
      psrg_st_hold: begin
        // Oscillator sags while held, so a long reset means a long relock
        if (step && vco != 8'h00) begin
          next_vco = vco - 8'h01; // RULE8
        end
        if (!ext_reset_in && por_cnt == 32'h0) begin
          next_act_div = prof_div[sel]; // RULE16 RULE3
          next_act_skew = prof_skew[sel]; // RULE16 RULE3
          next_active_profile = sel; // RULE1
          next_state = psrg_st_acquire;
        end
      end
      psrg_st_acquire: begin
        if (step && vco < `PSRG_VCO_LOCK) begin
          next_vco = vco + 8'h01; // RULE9
        end
        if (vco == `PSRG_VCO_LOCK && aligned) begin
          next_state = psrg_st_locked;
          ev_gained = 1'b1;
        end
      end
      psrg_st_locked: begin
        if (!aligned) begin
          next_state = psrg_st_acquire;
          ev_lost = 1'b1;
        end
      end
      default: next_state = psrg_st_hold;
    endcase
    if (ext_reset_in) begin
      next_state = psrg_st_hold; // RULE7
      ev_lost = state == psrg_st_locked;
    end
  end

  assign lock = state == psrg_st_locked; // RULE7

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= psrg_st_hold;
      por_cnt <= 32'(POR_CYCLES);
      vco <= `PSRG_VCO_START; // RULE9
      step_cnt <= 8'h00;
      act_div <= `PSRG_DIV_RST;
      act_skew <= `PSRG_SKEW_RST;
      active_profile <= 2'b00;
    end else begin
      state <= next_state;
      por_cnt <= next_por_cnt;
      vco <= next_vco;
      step_cnt <= next_step_cnt;
      act_div <= next_act_div;
      act_skew <= next_act_skew;
      active_profile <= next_active_profile;
    end
  end

  // ------------------------------------------------------------------
  // Dividers, phase detector and output gating
  // ------------------------------------------------------------------
  logic [6:0]       ref_cnt, fb_cnt, out_cnt, next_ref_cnt, next_fb_cnt, next_out_cnt;
  logic             ref_q, fb_q, next_aligned;
  logic [BANKS-1:0] tog, next_tog, next_bank_out, next_bank_oe_n;

  function automatic logic [6:0] lim(input logic [6:0] d);
    return (d == 7'h00) ? 7'h00 : d - 7'h01;
  endfunction

  always_comb begin
    logic       re, pfd, fb_edge, hold, coarse;
    logic [6:0] skw;
    skw = 7'h00;
    fb_edge = 1'b0;
    re = ref_clk_in && !ref_q;
    hold = state == psrg_st_hold;
    coarse = common[`PSRG_COARSE_BIT];
    pfd = re && ref_cnt == 7'h00;
    if (act_skew[`PSRG_INT_FB_BIT]) begin
      // Skew at or above the feedback divide never aligns and stays unlocked
      fb_edge = re && fb_cnt == {3'h0, act_skew[`PSRG_FB_SKEW_LSB +: 4]} << coarse; // RULE15
    end else begin
      fb_edge = feedback_in && !fb_q; // RULE14
    end
    next_ref_cnt = ref_cnt;
    next_fb_cnt = fb_cnt;
    next_out_cnt = out_cnt;
    next_aligned = aligned;
    next_tog = tog;
    if (hold) begin
      next_ref_cnt = 7'h00; // RULE7
      next_fb_cnt = 7'h00; // RULE7
      next_out_cnt = 7'h00; // RULE7
      next_tog = '0; // RULE7
      next_aligned = 1'b0;
    end else begin
      if (re) begin
        next_ref_cnt = (ref_cnt >= lim({1'b0, act_div[`PSRG_REF_DIV_LSB +: 6]})) ? 7'h00 : ref_cnt + 7'h01;
        next_out_cnt = (out_cnt >= lim(act_div[`PSRG_OUT_DIV_LSB +: 7])) ? 7'h00 : out_cnt + 7'h01;
        // Feedback divider slips one edge when the reference leads
        if (!(pfd && !fb_edge)) begin
          next_fb_cnt = (fb_cnt >= lim({1'b0, act_div[`PSRG_FB_DIV_LSB +: 6]})) ? 7'h00 : fb_cnt + 7'h01; // RULE14
        end
        for (int i = 0; i < BANKS; i++) begin
          skw = {3'h0, act_skew[i*4 +: 4]} << coarse;
          if (out_cnt == skw) begin
            next_tog[i] = !tog[i]; // RULE3
          end
        end
      end
      if (pfd) begin
        next_aligned = fb_edge; // RULE14
      end
    end
    for (int i = 0; i < BANKS; i++) begin
      next_bank_out[i] = output_static_gate ? (tog[i] ^ common[i]) : common[i]; // RULE10 RULE4
      next_bank_oe_n[i] = (i < BANKS / 2) ? bank_group_x_enable_n : bank_group_y_enable_n; // RULE11
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ref_cnt <= 7'h00;
      fb_cnt <= 7'h00;
      out_cnt <= 7'h00;
      ref_q <= 1'b0;
      fb_q <= 1'b0;
      aligned <= 1'b0;
      tog <= '0;
      bank_out <= '0;
      bank_oe_n <= '1;
    end else begin
      ref_cnt <= next_ref_cnt;
      fb_cnt <= next_fb_cnt;
      out_cnt <= next_out_cnt;
      ref_q <= ref_clk_in;
      fb_q <= feedback_in;
      aligned <= next_aligned;
      tog <= next_tog;
      bank_out <= next_bank_out;
      bank_oe_n <= next_bank_oe_n;
    end
  end
endmodule // psrg_top
`default_nettype wire

// ===== verification/profile_select_reset_gating_tb.sv
/*
  Bench for psrg_top: registers, power-up, profiles, relock, gating, irq.
  Assumes psrg_board_model supplies reference, feedback and gate.
*/
`timescale 1ns/1ps
`default_nettype none
module profile_select_reset_gating_tb;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        profile_sel_bit0 = 1'b0;
  logic        profile_sel_bit1 = 1'b0;
  logic        ext_reset_in = 1'b0;
  logic        gate_en = 1'b1;
  logic        bank_group_x_enable_n = 1'b0;
  logic        bank_group_y_enable_n = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        lock, irq, ref_clk_in, feedback_in, output_static_gate;
  logic [1:0]  s_axi_bresp, s_axi_rresp, active_profile, en;
  logic [31:0] s_axi_rdata, v;
  logic [3:0]  bank_out, bank_oe_n, seen;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          t0, dt_s, i;
  always #2 sys_clk = ~sys_clk;
  psrg_top #(.POR_CYCLES(4)) psrg_top_i (.*);
  psrg_board_model psrg_board_model_i (.*);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp_bus(input logic [33:0] e, input logic [33:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: bus %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_pin(input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: pins %h expected %h", $time, g, e);
    end
  endtask
  // Ready and valid are read at the falling edge, before the rising edge uses them
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w, b;
    @(posedge sys_clk);
    exp_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge sys_clk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      @(posedge sys_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ar, rv;
    @(posedge sys_clk);
    exp_r.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rv = 1'b0;
    while (!rv) begin
      @(negedge sys_clk);
      ar = s_axi_arready;
      rv = s_axi_rvalid;
      @(posedge sys_clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_lock;
    do @(negedge sys_clk); while (lock !== 1'b1);
  endtask
  task automatic pulse(input int n);
    @(posedge sys_clk);
    ext_reset_in <= 1'b1;
    repeat (n) @(posedge sys_clk);
    ext_reset_in <= 1'b0;
    t0 = cyc;
  endtask
  always @(negedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready) cmp_bus(exp_r.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) cmp_bus({32'h0, exp_b.pop_front()}, {32'h0, s_axi_bresp});
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    v = $urandom(16);
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    t0 = cyc;
    for (i = 0; i < 4; i++) begin
      rd(8'(32 + 8 * i), 32'h00040101, 2'b00);
      rd(8'(36 + 8 * i), 32'h0, 2'b00);
    end
    v = $urandom();
    rd(8'h40, 32'h0, 2'b10);
    wr(8'h40, v, 2'b10);
    wr(8'h04, v, 2'b00);
    rd(8'h04, v, 2'b00);
    $display("registers done");
    wait_lock();
    cmp_pin(8'h01, {7'h0, (cyc - t0) > 1400});
    rd(8'h08, 32'h1, 2'b00);
    $display("power-up done");
    for (i = 3; i >= 0; i--) begin
      // Skews stay below the output divide so every bank toggles later;
      // odd profiles close the loop internally with zero feedback skew
      v = ($urandom() & 32'h00003333) | {7'h0, i[0], 24'h0};
      wr(8'(36 + 8 * i), v, 2'b00);
      rd(8'(36 + 8 * i), v, 2'b00);
      {profile_sel_bit1, profile_sel_bit0} <= 2'(i);
      repeat (3) @(negedge sys_clk);
      cmp_pin(8'((i + 1) % 4), {6'h0, active_profile});
      pulse(10);
      repeat (3) @(negedge sys_clk);
      cmp_pin(8'(i), {6'h0, active_profile});
      wait_lock();
      rd(8'h08, 32'(2 * i + 1), 2'b00);
    end
    $display("profiles done");
    pulse(20);
    wait_lock();
    dt_s = cyc - t0;
    pulse(400);
    wait_lock();
    cmp_pin(8'h01, {7'h0, (cyc - t0) > dt_s + 300});
    $display("relock done");
    wr(8'h00, 32'h5, 2'b00);
    gate_en <= 1'b0;
    repeat (44) @(negedge sys_clk);
    cmp_pin(8'h05, {4'h0, bank_out});
    @(posedge sys_clk);
    gate_en <= 1'b1;
    seen = 4'h0;
    repeat (80) begin
      @(negedge sys_clk);
      seen = seen | (bank_out ^ 4'h5);
    end
    cmp_pin(8'h0f, {4'h0, seen});
    for (i = 1; i < 5; i++) begin
      en = 2'(i);
      @(posedge sys_clk);
      {bank_group_y_enable_n, bank_group_x_enable_n} <= en;
      repeat (2) @(negedge sys_clk);
      cmp_pin({4'h0, {2{en[1]}}, {2{en[0]}}}, {4'h0, bank_oe_n});
    end
    $display("gating done");
    wr(8'h0c, 32'h3, 2'b00);
    wr(8'h10, 32'h3, 2'b00);
    @(negedge sys_clk);
    cmp_pin(8'h00, {7'h0, irq});
    @(posedge sys_clk);
    ext_reset_in <= 1'b1;
    repeat (3) @(negedge sys_clk);
    cmp_pin(8'h01, {7'h0, irq});
    rd(8'h0c, 32'h2, 2'b00);
    wr(8'h10, 32'h1, 2'b00);
    @(negedge sys_clk);
    cmp_pin(8'h00, {7'h0, irq});
    wr(8'h0c, 32'h2, 2'b00);
    rd(8'h0c, 32'h0, 2'b00);
    @(posedge sys_clk);
    ext_reset_in <= 1'b0;
    wait_lock();
    repeat (2) @(negedge sys_clk);
    cmp_pin(8'h01, {7'h0, irq});
    wr(8'h0c, 32'h1, 2'b00);
    @(negedge sys_clk);
    cmp_pin(8'h00, {7'h0, irq});
    $display("interrupt done");
    complete_run();
  end
endmodule // profile_select_reset_gating_tb
`default_nettype wire

// ===== verification/psrg_board_model.sv
/*
  Board logic model: reference clock, external feedback, lock-driven gate.
  Assumes the bench clock; the reference runs at an eighth of it.
*/
`timescale 1ns/1ps
`default_nettype none
module psrg_board_model (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic lock,
  input  wire logic gate_en,
  output logic      ref_clk_in,
  output logic      feedback_in,
  output logic      output_static_gate
);
  logic [1:0] phase;
  logic [1:0] next_phase;
  logic       next_ref;
  always_comb begin
    next_phase = phase + 2'h1;
    next_ref = ref_clk_in ^ (phase == 2'h3);
  end
  // Four cycles high and four low, so a reset for bad pulse widths is never due
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      phase <= 2'h0;
      ref_clk_in <= 1'b0;
      feedback_in <= 1'b0;
      output_static_gate <= 1'b0;
    end else begin
      phase <= next_phase;
      ref_clk_in <= next_ref;
      feedback_in <= next_ref;
      output_static_gate <= lock && gate_en;
    end
  end
endmodule // psrg_board_model
`default_nettype wire

// ===== verification/psrg_checker.sv
/*
  Port checker for psrg_top: lock, profile loading and output gating.
  Assumes it is bound to psrg_top with the same parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module psrg_checker #(
  parameter int BANKS      = 4,
  parameter int POR_CYCLES = 4
) (
  input wire logic             sys_clk,
  input wire logic             reset,
  input wire logic             ext_reset_in,
  input wire logic             profile_sel_bit0,
  input wire logic             profile_sel_bit1,
  input wire logic             output_static_gate,
  input wire logic             bank_group_x_enable_n,
  input wire logic             bank_group_y_enable_n,
  input wire logic             lock,
  input wire logic [1:0]       active_profile,
  input wire logic [BANKS-1:0] bank_out,
  input wire logic [BANKS-1:0] bank_oe_n
);
  // ----------------------------------------
  // Cycles since power-up, saturating
  // ----------------------------------------
  logic [15:0] since;
  logic [15:0] next_since;
  always_comb begin
    next_since = since;
    if (since != 16'hffff) next_since = since + 16'h0001;
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) since <= 16'h0000;
    else since <= next_since;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_RESET_DROPS_LOCK: assert property (ext_reset_in |=> !lock)
    else $error("lock stayed up under external reset");
  AST_POR_HOLD: assert property (since < POR_CYCLES - 1 |-> !lock && active_profile == 2'b00)
    else $error("activity during power-up hold");
  // Ramp from the low start takes 150 steps of 10 cycles; 1400 leaves margin
  AST_SLOW_START: assert property (lock |-> since >= 16'd1400)
    else $error("lock before oscillator ramp");
  AST_GATE_STATIC: assert property ((!output_static_gate)[*2] |=> $stable(bank_out))
    else $error("bank output moved while gated");
  AST_OE_X: assert property (!$past(reset) |-> bank_oe_n[0] == $past(bank_group_x_enable_n))
    else $error("x group enable not followed");
  AST_OE_Y: assert property (!$past(reset) |-> bank_oe_n[BANKS-1] == $past(bank_group_y_enable_n))
    else $error("y group enable not followed");
  AST_PROFILE_FROZEN: assert property (ext_reset_in && $past(ext_reset_in) |=> $stable(active_profile))
    else $error("profile changed while reset held");
  AST_PROFILE_DECODE: assert property ($changed(active_profile) |->
    active_profile == $past({profile_sel_bit1, profile_sel_bit0}) && !$past(ext_reset_in))
    else $error("profile loaded wrongly");
endmodule // psrg_checker
bind psrg_top psrg_checker #(.BANKS(BANKS), .POR_CYCLES(POR_CYCLES)) psrg_checker_i (.*);
`default_nettype wire
